// ==== src/tmr_top.sv ====
// dual timer/counter with shared mode register, reached through the special function port
// assumes count and gate pins are asynchronous and a core issuing single-cycle byte accesses
`timescale 1ns/100ps
`include "tmr_consts.svh"

module tmr_top (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire tmr_pkg::tmr_byte_type sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output tmr_pkg::tmr_byte_type sfr_rdata_o,
  input wire logic first_count_pin_i,
  input wire logic second_count_pin_i,
  input wire logic first_gate_pin_i,
  input wire logic second_gate_pin_i,
  input wire logic first_vector_ack_i,
  input wire logic second_vector_ack_i,
  output logic first_timer_overflow_o,
  output logic second_timer_overflow_o
);
  import tmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic sample_stb; // one cycle at the sample phase
  logic update_stb; // one cycle at the update phase

  logic [1:0] pin_async; // raw count pins, index = timer
  logic [1:0] gate_async; // raw gate pins
  logic [1:0] pin_meta; // first synchroniser stage, count pins
  logic [1:0] pin_sync; // second stage
  logic [1:0] gate_meta; // first synchroniser stage, gate pins
  logic [1:0] gate_sync; // second stage
  logic [1:0] pin_sample; // level taken at the last sample phase
  logic [1:0] next_pin_sample;
  logic [1:0] edge_pend; // falling edge seen, waiting for update phase
  logic [1:0] next_edge_pend;

  tmr_byte_type timer_mode_config; // mode register
  tmr_byte_type next_timer_mode_config;
  logic first_timer_run; // run bits
  logic second_timer_run;
  logic next_first_timer_run;
  logic next_second_timer_run;
  logic first_timer_overflow; // overflow flags
  logic second_timer_overflow;
  logic next_first_timer_overflow;
  logic next_second_timer_overflow;
  tmr_byte_type first_timer_low_byte; // count bytes
  tmr_byte_type first_timer_high_byte;
  tmr_byte_type second_timer_low_byte;
  tmr_byte_type second_timer_high_byte;
  tmr_byte_type next_first_timer_low_byte;
  tmr_byte_type next_first_timer_high_byte;
  tmr_byte_type next_second_timer_low_byte;
  tmr_byte_type next_second_timer_high_byte;
  tmr_byte_type next_sfr_rdata;

  tmr_mode_type mode0; // decoded modes
  tmr_mode_type mode1;
  logic [1:0] gate_en; // gating bits
  logic [1:0] src_pin; // source select bits
  logic [1:0] run_ok; // run and gate condition met
  logic [1:0] step_src; // increment source available this update
  logic tick0; // timer zero low byte advances
  logic tick1; // timer one advances
  logic tick_split; // timer zero high byte in split mode
  logic [16:0] step0; // {overflow, high, low} for timer zero
  logic [16:0] step1; // same for timer one
  logic [8:0] split_hi; // {overflow, byte} for split high byte
  logic ovf0_set; // overflow events
  logic ovf1_set;

  assign pin_async = {second_count_pin_i, first_count_pin_i};
  assign gate_async = {second_gate_pin_i, first_gate_pin_i};

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle phase generator
  tmr_phase_gen u_phase (
    .ref_clk_i (ref_clk_i),
    .resetn_i (resetn_i),
    .phase_o (),
    .sample_stb_o (sample_stb),
    .update_stb_o (update_stb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-timer pin synchronisers and falling-edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      // edge found at sample phase, consumed at next update phase
      always_comb begin
        next_pin_sample[gi] = pin_sample[gi];
        next_edge_pend[gi] = edge_pend[gi];
        if (update_stb) begin
          next_edge_pend[gi] = 1'b0; // edge consumed at update phase [RULE4]
        end
        if (sample_stb) begin
          next_pin_sample[gi] = pin_sync[gi]; // one sample per machine cycle [RULE3]
          if (pin_sample[gi] && !pin_sync[gi]) begin
            next_edge_pend[gi] = 1'b1; // high then low across two cycles [RULE3] [RULE5]
          end
        end
      end

      // two-stage sync, then sample and pending registers
      always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
          gate_meta[gi] <= 1'b0;
          gate_sync[gi] <= 1'b0;
          pin_sample[gi] <= 1'b0;
          edge_pend[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_async[gi];
          pin_sync[gi] <= pin_meta[gi];
          gate_meta[gi] <= gate_async[gi];
          gate_sync[gi] <= gate_meta[gi];
          pin_sample[gi] <= next_pin_sample[gi];
          edge_pend[gi] <= next_edge_pend[gi];
        end
      end

      // gating and source selection from the mode nibble
      assign gate_en[gi] = timer_mode_config[gi*4 + `TMR_NIB_GATE];
      assign src_pin[gi] = timer_mode_config[gi*4 + `TMR_NIB_SRC];
      // pin edge when counting, every machine cycle when timing [RULE9] [RULE2]
      assign step_src[gi] = src_pin[gi] ? edge_pend[gi] : 1'b1;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // count enables
  assign mode0 = tmr_mode_type'(timer_mode_config[1:0]);
  assign mode1 = tmr_mode_type'(timer_mode_config[5:4]);
  // run bit alone, or run bit and gate pin high when gating [RULE8] [RULE16]
  assign run_ok[0] = first_timer_run && (!gate_en[0] || gate_sync[0]);
  assign run_ok[1] = second_timer_run && (!gate_en[1] || gate_sync[1]);
  assign tick0 = update_stb && run_ok[0] && step_src[0];
  // timer one held in mode 11 [RULE13]
  assign tick1 = update_stb && run_ok[1] && step_src[1] && (mode1 != TMR_MODE_SPLIT);
  // split high byte: machine cycles only, timer one run bit [RULE14]
  assign tick_split = update_stb && second_timer_run && (mode0 == TMR_MODE_SPLIT);

  ////////////////////////////////////////////////////////////////////////////
  // one count step for a timer in a given mode, returns {overflow, high, low}
  function automatic logic [16:0] count_step(input tmr_mode_type mode, input tmr_byte_type lo,
                                             input tmr_byte_type hi, input logic tick);
    logic [16:0] res;
    logic [16:0] wide;
    res = {1'b0, hi, lo};
    wide = 17'h00000;
    if (tick) begin
      case (mode)
        TMR_MODE_13BIT: begin
          // low five bits prescale, top three bits of low byte left alone [RULE10] [RULE17]
          if (lo[4:0] == `TMR_PRESCALE_MAX) begin
            res = {(hi == 8'hFF), hi + 8'h01, lo[7:5], 5'h00};
          end else begin
            res = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
          end
        end
        TMR_MODE_16BIT: begin
          wide = {1'b0, hi, lo} + 17'h00001; // cascaded, carry is overflow [RULE11]
          res = wide;
        end
        TMR_MODE_RELOAD: begin
          if (lo == 8'hFF) begin
            res = {1'b1, hi, hi}; // reload low from high, high untouched [RULE12] [RULE17]
          end else begin
            res = {1'b0, hi, lo + 8'h01};
          end
        end
        TMR_MODE_SPLIT: begin
          // low byte alone as 8-bit counter (timer zero only reaches here) [RULE14]
          res = {(lo == 8'hFF), hi, lo + 8'h01};
        end
        default: begin
          res = {1'b0, hi, lo};
        end
      endcase
    end
    return res;
  endfunction : count_step

  assign step0 = count_step(mode0, first_timer_low_byte, first_timer_high_byte, tick0);
  assign step1 = count_step(mode1, second_timer_low_byte, second_timer_high_byte, tick1);
  assign split_hi = tick_split ? ({1'b0, first_timer_high_byte} + 9'h001) : {1'b0, first_timer_high_byte};
  assign ovf0_set = step0[16];
  // in split mode the high byte of timer zero owns the second flag [RULE14]
  assign ovf1_set = (mode0 == TMR_MODE_SPLIT) ? split_hi[8] : step1[16];

  ////////////////////////////////////////////////////////////////////////////
  // register file next values: counting, then software writes on top
  always_comb begin
    next_timer_mode_config = timer_mode_config;
    next_first_timer_run = first_timer_run;
    next_second_timer_run = second_timer_run;
    next_first_timer_overflow = first_timer_overflow;
    next_second_timer_overflow = second_timer_overflow;
    next_first_timer_low_byte = step0[7:0];
    next_first_timer_high_byte = (mode0 == TMR_MODE_SPLIT) ? split_hi[7:0] : step0[15:8];
    next_second_timer_low_byte = step1[7:0];
    next_second_timer_high_byte = step1[15:8];
    // vector acknowledge clears the flags [RULE15]
    if (first_vector_ack_i) begin
      next_first_timer_overflow = 1'b0;
    end
    if (second_vector_ack_i) begin
      next_second_timer_overflow = 1'b0;
    end
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        `TMR_ADDR_RUN_FLAG: begin
          // run bits written by software, counts untouched [RULE16]
          next_first_timer_run = sfr_wdata_i[`TMR_BIT_RUN0];
          next_second_timer_run = sfr_wdata_i[`TMR_BIT_RUN1];
          next_first_timer_overflow = sfr_wdata_i[`TMR_BIT_OVF0];
          next_second_timer_overflow = sfr_wdata_i[`TMR_BIT_OVF1];
        end
        `TMR_ADDR_MODE: begin
          next_timer_mode_config = sfr_wdata_i; // [RULE7]
        end
        `TMR_ADDR_LOW0: begin
          next_first_timer_low_byte = sfr_wdata_i; // write beats increment [RULE18] [RULE1]
        end
        `TMR_ADDR_HIGH0: begin
          next_first_timer_high_byte = sfr_wdata_i; // [RULE18] [RULE1]
        end
        `TMR_ADDR_LOW1: begin
          next_second_timer_low_byte = sfr_wdata_i; // [RULE18] [RULE1]
        end
        `TMR_ADDR_HIGH1: begin
          next_second_timer_high_byte = sfr_wdata_i; // [RULE18] [RULE1]
        end
        default: begin
          next_timer_mode_config = timer_mode_config; // unmapped write ignored
        end
      endcase
    end
    // hardware set wins over any clear in the same cycle [RULE15]
    if (ovf0_set) begin
      next_first_timer_overflow = 1'b1;
    end
    if (ovf1_set) begin
      next_second_timer_overflow = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux, registered; low control nibble and unmapped addresses read zero
  always_comb begin
    next_sfr_rdata = sfr_rdata_o;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        `TMR_ADDR_RUN_FLAG: begin
          next_sfr_rdata = {second_timer_overflow, second_timer_run, first_timer_overflow,
                            first_timer_run, 4'h0};
        end
        `TMR_ADDR_MODE: begin
          next_sfr_rdata = timer_mode_config;
        end
        `TMR_ADDR_LOW0: begin
          next_sfr_rdata = first_timer_low_byte;
        end
        `TMR_ADDR_HIGH0: begin
          next_sfr_rdata = first_timer_high_byte;
        end
        `TMR_ADDR_LOW1: begin
          next_sfr_rdata = second_timer_low_byte;
        end
        `TMR_ADDR_HIGH1: begin
          next_sfr_rdata = second_timer_high_byte;
        end
        default: begin
          next_sfr_rdata = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and outputs
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      timer_mode_config <= `TMR_MODE_RESET; // [RULE7]
      first_timer_run <= 1'b0;
      second_timer_run <= 1'b0;
      first_timer_overflow <= 1'b0;
      second_timer_overflow <= 1'b0;
      first_timer_low_byte <= `TMR_BYTE_RESET;
      first_timer_high_byte <= `TMR_BYTE_RESET;
      second_timer_low_byte <= `TMR_BYTE_RESET;
      second_timer_high_byte <= `TMR_BYTE_RESET;
      sfr_rdata_o <= 8'h00;
      first_timer_overflow_o <= 1'b0;
      second_timer_overflow_o <= 1'b0;
    end else begin
      timer_mode_config <= next_timer_mode_config;
      first_timer_run <= next_first_timer_run;
      second_timer_run <= next_second_timer_run;
      first_timer_overflow <= next_first_timer_overflow;
      second_timer_overflow <= next_second_timer_overflow;
      first_timer_low_byte <= next_first_timer_low_byte;
      first_timer_high_byte <= next_first_timer_high_byte;
      second_timer_low_byte <= next_second_timer_low_byte;
      second_timer_high_byte <= next_second_timer_high_byte;
      sfr_rdata_o <= next_sfr_rdata;
      first_timer_overflow_o <= next_first_timer_overflow;
      second_timer_overflow_o <= next_second_timer_overflow;
    end
  end

endmodule : tmr_top

// ==== src/tmr_consts.svh ====
// constants for the dual timer/counter: special function addresses, field positions, phases
// assumes the file is included by bare name from each design file that needs it
//
// Contract
// [RULE1] two 16-bit timers, separate byte registers
// [RULE2] timer function counts once per machine cycle
// [RULE3] count pin sampled at sample_phase, falling edge
// [RULE4] counted edge appears at next update_phase
// [RULE5] edge recognition spans two machine cycles
// [RULE6] source holds each level one machine cycle
// [RULE7] mode register at 89H, resets 00H
// [RULE8] gate bit adds gate pin high condition
// [RULE9] source select picks pin edges or cycles
// [RULE10] mode 00: 13-bit with 5-bit prescaler
// [RULE11] mode 01: cascaded 16-bit counter
// [RULE12] mode 10: low byte reloads from high
// [RULE13] timer one in mode 11 holds count
// [RULE14] timer zero mode 11 splits two bytes
// [RULE15] overflow flag set by hardware, vector clears
// [RULE16] run bit starts/stops, never clears counts
// [RULE17] reload keeps high byte; prescaler top ignored
// [RULE18] software byte write overrides coincident increment
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// special function register addresses
`define TMR_ADDR_RUN_FLAG 8'h88
`define TMR_ADDR_MODE 8'h89
`define TMR_ADDR_LOW0 8'h8A
`define TMR_ADDR_LOW1 8'h8B
`define TMR_ADDR_HIGH0 8'h8C
`define TMR_ADDR_HIGH1 8'h8D

// reset values
`define TMR_MODE_RESET 8'h00
`define TMR_BYTE_RESET 8'h00

// run/flag control bit positions
`define TMR_BIT_OVF1 7
`define TMR_BIT_RUN1 6
`define TMR_BIT_OVF0 5
`define TMR_BIT_RUN0 4

// mode register fields, per nibble (timer one upper, timer zero lower)
`define TMR_NIB_GATE 3
`define TMR_NIB_SRC 2
`define TMR_NIB_MODE_HI 1
`define TMR_NIB_MODE_LO 0

// machine cycle: twelve core clocks, phase index = (state-1)*2 + (part-1)
`define TMR_CLKS_PER_MC 4'hC
`define TMR_PHASE_LAST 4'hB
`define TMR_SAMPLE_PHASE 4'h9
`define TMR_UPDATE_PHASE 4'h4

// prescaler terminal count in 13-bit mode
`define TMR_PRESCALE_MAX 5'h1F

`endif

// ==== src/tmr_pkg.sv ====
// types shared by the dual timer/counter
// assumes tmr_consts.svh carries every numeric constant
package tmr_pkg;

  // one special function register byte
  typedef logic [7:0] tmr_byte_type;

  // per-timer operating mode, from the two mode bits
  typedef enum logic [1:0] {
    TMR_MODE_13BIT = 2'h0,
    TMR_MODE_16BIT = 2'h1,
    TMR_MODE_RELOAD = 2'h2,
    TMR_MODE_SPLIT = 2'h3
  } tmr_mode_type;

  // machine cycle phase index 0..11
  typedef logic [3:0] tmr_phase_type;

endpackage : tmr_pkg

// ==== src/tmr_phase_gen.sv ====
// machine cycle phase generator: divides the core clock by twelve
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/100ps
`include "tmr_consts.svh"

module tmr_phase_gen (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  output tmr_pkg::tmr_phase_type phase_o,
  output logic sample_stb_o,
  output logic update_stb_o
);
  import tmr_pkg::*;

  tmr_phase_type phase; // current phase index
  tmr_phase_type next_phase; // phase after this clock
  logic next_sample_stb; // pulse in the sample phase
  logic next_update_stb; // pulse in the update phase

  ////////////////////////////////////////////////////////////////////////////
  // phase counter, strobes follow the phase they mark
  always_comb begin
    if (phase == `TMR_PHASE_LAST) begin
      next_phase = 4'h0; // wrap at end of machine cycle
    end else begin
      next_phase = phase + 4'h1;
    end
    next_sample_stb = (next_phase == `TMR_SAMPLE_PHASE); // [RULE3]
    next_update_stb = (next_phase == `TMR_UPDATE_PHASE); // [RULE2] [RULE4]
  end

  // registers only
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      phase <= 4'h0;
      sample_stb_o <= 1'b0;
      update_stb_o <= 1'b0;
    end else begin
      phase <= next_phase;
      sample_stb_o <= next_sample_stb;
      update_stb_o <= next_update_stb;
    end
  end

  assign phase_o = phase;

endmodule : tmr_phase_gen

// ==== verif/tmr_monitor.sv ====
// port checker for the dual timer/counter
// assumes it is bound onto tmr_top and sees one clock domain
`timescale 1ns/100ps

module tmr_monitor (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire tmr_pkg::tmr_byte_type sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire tmr_pkg::tmr_byte_type sfr_rdata_o,
  input wire logic first_vector_ack_i,
  input wire logic second_vector_ack_i,
  input wire logic first_timer_overflow_o,
  input wire logic second_timer_overflow_o
);
  import tmr_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic ctl_rd; // read of the run/flag byte
  logic clr0; // a legal cause for timer zero flag to drop
  logic clr1; // a legal cause for timer one flag to drop
  assign ctl_rd = sfr_rd_i && sfr_addr_i == 8'h88;
  assign clr0 = first_vector_ack_i || (sfr_wr_i && sfr_addr_i == 8'h88 && !sfr_wdata_i[5]);
  assign clr1 = second_vector_ack_i || (sfr_wr_i && sfr_addr_i == 8'h88 && !sfr_wdata_i[7]);
  ////////////////////////////////////////////////////////////////////////////////
  reset_clear_a: assert property ($past(!resetn_i) |->
    sfr_rdata_o == 8'h00 && !first_timer_overflow_o && !second_timer_overflow_o) else $error("outputs not cleared");
  rdata_hold_a: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("read data moved");
  unmapped_read_a: assert property (sfr_rd_i && !(sfr_addr_i inside {[8'h88:8'h8D]}) |=>
    sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  flag_read_a: assert property (ctl_rd |=> sfr_rdata_o[3:0] == 4'h0 &&
    sfr_rdata_o[7] == $past(second_timer_overflow_o) && sfr_rdata_o[5] == $past(first_timer_overflow_o))
    else $error("run/flag read wrong");
  flag0_fall_a: assert property ($fell(first_timer_overflow_o) |-> $past(clr0)) else $error("flag0 dropped");
  flag1_fall_a: assert property ($fell(second_timer_overflow_o) |-> $past(clr1)) else $error("flag1 dropped");
  mode_read_a: assert property (sfr_wr_i && sfr_addr_i == 8'h89 ##1 sfr_rd_i && !sfr_wr_i &&
    sfr_addr_i == 8'h89 |=> sfr_rdata_o == $past(sfr_wdata_i, 2)) else $error("mode readback wrong");
  byte_write_a: assert property (sfr_wr_i && sfr_addr_i inside {[8'h8A:8'h8D]} ##1 sfr_rd_i && !sfr_wr_i &&
    sfr_addr_i == $past(sfr_addr_i) |=> sfr_rdata_o == $past(sfr_wdata_i, 2)) else $error("count byte write lost");
  run_read_a: assert property (sfr_wr_i && sfr_addr_i == 8'h88 ##1 ctl_rd && !sfr_wr_i |=>
    (sfr_rdata_o & 8'h50) == ($past(sfr_wdata_i, 2) & 8'h50)) else $error("run bits readback wrong");
  // main scenarios
  ack_cov: cover property (first_vector_ack_i && first_timer_overflow_o);
  ovf1_cov: cover property ($rose(second_timer_overflow_o));
  ctl_cov: cover property (ctl_rd && first_timer_overflow_o);
endmodule : tmr_monitor

bind tmr_top tmr_monitor i_tmr_monitor (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i),
  .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o),
  .first_vector_ack_i(first_vector_ack_i),
  .second_vector_ack_i(second_vector_ack_i),
  .first_timer_overflow_o(first_timer_overflow_o),
  .second_timer_overflow_o(second_timer_overflow_o)
);

// ==== verif/tmr_pin_model.sv ====
// behavioural source for the two count pins: bursts of falling edges
// assumes go_i is a one-cycle pulse and edges_i/hold_i stay put meanwhile
`timescale 1ns/100ps

module tmr_pin_model (
  input wire logic ref_clk_i,
  input wire logic [1:0] go_i,
  input wire logic [7:0] edges_i,
  input wire logic [4:0] hold_i,
  output logic first_count_pin_o,
  output logic second_count_pin_o,
  output logic busy_o
);
  logic [1:0] sel; // which pins take part in the burst
  // pins idle high so the first low is a real falling edge
  initial begin
    first_count_pin_o = 1'b1;
    second_count_pin_o = 1'b1;
    busy_o = 1'b0;
    sel = 2'b00;
  end
  // each level stands hold_i clocks, one machine cycle or more only when hold_i is 12 or more
  always begin
    @(posedge ref_clk_i);
    if (go_i != 2'b00) begin
      sel = go_i;
      busy_o <= 1'b1;
      repeat (edges_i) begin
        first_count_pin_o <= !sel[0];
        second_count_pin_o <= !sel[1];
        repeat (hold_i) @(posedge ref_clk_i);
        first_count_pin_o <= 1'b1;
        second_count_pin_o <= 1'b1;
        repeat (hold_i) @(posedge ref_clk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule : tmr_pin_model

// ==== verif/tb.sv ====
// self-checking bench for the dual timer/counter
// assumes tmr_top, tmr_pin_model and the bound checker are compiled first
`timescale 1ns/100ps

module tb;
  import tmr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  tmr_byte_type wdata = 8'h00;
  tmr_byte_type rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic g0 = 1'b1;
  logic g1 = 1'b1;
  logic ack0 = 1'b0;
  logic ack1 = 1'b0;
  logic [1:0] go = 2'b00;
  logic [7:0] nedge = 8'h01;
  logic [4:0] hold = 5'h0C;
  logic c0, c1, busy, ovf0, ovf1;
  logic [31:0] seed = 32'h175E;
  int errors = 0;
  int checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  tmr_top i_tmr_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .first_count_pin_i(c0), .second_count_pin_i(c1),
    .first_gate_pin_i(g0), .second_gate_pin_i(g1), .first_vector_ack_i(ack0), .second_vector_ack_i(ack1),
    .first_timer_overflow_o(ovf0), .second_timer_overflow_o(ovf1));
  tmr_pin_model i_tmr_pin_model (.ref_clk_i(ref_clk_i), .go_i(go), .edges_i(nedge), .hold_i(hold),
    .first_count_pin_o(c0), .second_count_pin_o(c1), .busy_o(busy));
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected {flag, high, low} after n increments in mode m
  function automatic logic [16:0] step(input logic [1:0] m, input logic [16:0] s, input int n);
    logic c;
    logic [16:0] v;
    v = s;
    for (int i = 0; i < n; i++) begin
      c = 1'b0;
      case (m)
        2'h0: begin
          v[4:0] = v[4:0] + 5'h01;
          if (v[4:0] == 5'h00) {c, v[15:8]} = {1'b0, v[15:8]} + 9'h001;
        end
        2'h1: {c, v[15:0]} = {1'b0, v[15:0]} + 17'h00001;
        2'h2: {c, v[7:0]} = (v[7:0] == 8'hFF) ? {1'b1, v[15:8]} : {1'b0, v[7:0] + 8'h01};
        default: {c, v[7:0]} = {1'b0, v[7:0]} + 9'h001;
      endcase
      v[16] = v[16] | c;
    end
    return v;
  endfunction : step
  // one bus cycle, taken at the next rising edge
  task automatic sfr_op(input logic w, input logic r, input logic [7:0] a, input tmr_byte_type d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
  endtask : sfr_op
  task automatic sfr_write(input logic [7:0] a, input tmr_byte_type d);
    sfr_op(1'b1, 1'b0, a, d);
    sfr_op(1'b0, 1'b0, a, d);
  endtask : sfr_write
  task automatic cmp_byte(input string what, input tmr_byte_type exp, input tmr_byte_type got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte
  // read back; w set means a write to the same place just before
  task automatic chk_reg(input string what, input logic [7:0] a, input tmr_byte_type exp, input logic w,
      input tmr_byte_type d);
    if (w) sfr_op(1'b1, 1'b0, a, d);
    sfr_op(1'b0, 1'b1, a, 8'h00);
    sfr_op(1'b0, 1'b0, a, 8'h00);
    cmp_byte(what, exp, rdata);
  endtask : chk_reg
  task automatic chk_state(input string what, input int t, input logic [16:0] e);
    chk_reg(what, 8'h8A + t[7:0], e[7:0], 1'b0, 8'h00);
    chk_reg(what, 8'h8C + t[7:0], e[15:8], 1'b0, 8'h00);
    cmp_byte(what, {7'h00, e[16]}, {7'h00, (t == 1) ? ovf1 : ovf0});
  endtask : chk_state
  // run for n machine cycles, then stop keeping the flags as they stand
  task automatic run_for(input tmr_byte_type ctl, input int n);
    sfr_write(8'h88, ctl);
    repeat (12 * n - 2) @(posedge ref_clk_i);
    sfr_write(8'h88, {ovf1, 1'b0, ovf0, 5'h00});
  endtask : run_for
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n, k;
    logic [1:0] m;
    logic [16:0] s;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    // reset values, an unmapped place and an ignored write
    sfr_write(8'h90, 8'hFF);
    for (int a = 8'h88; a < 8'h8E; a++) chk_reg("reset", a[7:0], 8'h00, 1'b0, 8'h00);
    chk_reg("unmapped", 8'h90, 8'h00, 1'b0, 8'h00);
    // random write then read, run bits too; low nibble of run/flag reads zero
    chk_reg("runflag", 8'h88, 8'h50, 1'b1, 8'h5F);
    for (int a = 8'h89; a < 8'h8E; a++) begin
      seed = lfsr(seed);
      chk_reg("readback", a[7:0], seed[7:0], 1'b1, seed[7:0]);
    end
    sfr_write(8'h88, 8'h00);
    $display("test registers done");
    // timer function in modes 00, 01, 10 and a random 16-bit case
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      m = (i == 3) ? 2'h1 : i[1:0];
      s = (i == 0) ? 17'h0FF1E : (i == 1) ? 17'h0FFFE : (i == 2) ? 17'h0F0FE : {2'b00, seed[14:0]};
      n = (i == 2) ? 4 : (i == 3) ? 1 + int'(seed[20:16]) : 3;
      sfr_write(8'h89, {6'h00, m});
      sfr_write(8'h8A, s[7:0]);
      sfr_write(8'h8C, s[15:8]);
      run_for(8'h10, n);
      s = step(m, s, n);
      chk_state("timer0", 0, s);
      if (s[16]) begin
        chk_reg("flag", 8'h88, 8'h20, 1'b0, 8'h00);
        ack0 <= 1'b1;
        @(posedge ref_clk_i);
        ack0 <= 1'b0;
        @(posedge ref_clk_i);
        cmp_byte("ack0", 8'h00, {7'h00, ovf0});
      end
    end
    $display("test modes done");
    // gate pin low holds the count, high lets it run
    for (int i = 0; i < 4; i++) begin
      sfr_write(8'h89, (i > 1) ? 8'h90 : 8'h09);
      sfr_write(8'h8A + i[8:1], 8'h00);
      sfr_write(8'h8C + i[8:1], 8'h00);
      g0 <= i[0];
      g1 <= i[0];
      run_for((i > 1) ? 8'h40 : 8'h10, 4);
      chk_state("gate", i / 2, step(2'h1, 17'h00000, 4 * i[0]));
    end
    $display("test gate done");
    // counter function on both pins, random edge count and level width
    for (int t = 0; t < 2; t++) begin
      seed = lfsr(seed);
      k = 3 + int'(seed[2:0]);
      sfr_write(8'h89, (t == 1) ? 8'h50 : 8'h05);
      sfr_write(8'h8A + t[7:0], 8'h00);
      sfr_write(8'h8C + t[7:0], 8'h00);
      sfr_write(8'h88, (t == 1) ? 8'h40 : 8'h10);
      nedge <= k[7:0];
      hold <= 5'h0C + {3'h0, seed[4:3]};
      go <= (t == 1) ? 2'b10 : 2'b01;
      @(posedge ref_clk_i);
      go <= 2'b00;
      n = 0;
      do begin
        @(posedge ref_clk_i);
        n++;
      end while (busy && n < 2000);
      if (n >= 2000) begin
        $display("ERROR pin model busy expected 0 seen 1");
        errors++;
        print_verdict();
      end
      repeat (40) @(posedge ref_clk_i);
      sfr_write(8'h88, 8'h00);
      chk_state("counter", t, step(2'h1, 17'h00000, k));
    end
    $display("test counter done");
    // split mode: timer one holds, timer zero high byte runs on timer one's run bit
    seed = lfsr(seed);
    sfr_write(8'h89, 8'h33);
    sfr_write(8'h8A, seed[7:0]);
    sfr_write(8'h8C, 8'hFE);
    sfr_write(8'h8B, seed[15:8]);
    sfr_write(8'h8D, seed[23:16]);
    run_for(8'h40, 3);
    chk_reg("hold0", 8'h8A, seed[7:0], 1'b0, 8'h00);
    chk_reg("split", 8'h8C, 8'h01, 1'b0, 8'h00);
    chk_state("hold1", 1, {1'b1, seed[23:8]});
    ack1 <= 1'b1;
    @(posedge ref_clk_i);
    ack1 <= 1'b0;
    @(posedge ref_clk_i);
    cmp_byte("ack1", 8'h00, {7'h00, ovf1});
    $display("test split done");
    print_verdict();
  end
endmodule : tb
